/* hrce_engine.sv */
// Purpose: Command decoder and executor of the heart-rate interface.
// Assumes: Link front ends deliver bytes on the core clock; pins are asynchronous.
// Notes: Serial commands are ASCII lines, I2C commands binary sequences ended by stop.
// How it works
// R01: Code 0x41 converts the named analog channel and returns one byte.
// R02: Code 0x44 sets each port pin's direction from a 5-bit mask, no reply.
// R03: Code 0x47 returns two status bytes then the requested history entries.
// R04: Code 0x49 returns the present level of all five port pins.
// R05: Code 0x4D returns the algorithm bit then the direction mask.
// R06: Code 0x4F sets the output level of each pin that is an output; input pins keep theirs, no reply.
// R07: Code 0x53 selects the algorithm and may request saving power-on defaults.
// R08: Code 0x56 returns a firmware type byte and a revision byte.
// R09: Channel above 3 drops the analog read; reply is ASCII or binary by link.
// R10: Wait 5 us after selecting the channel before starting conversion.
// R11: Mask bit 0 makes an output, 1 an input; bits 7:5 ignored.
// R12: Five port pins, one mask bit each.
// R13: After reset all pins are outputs driving zero.
// R14: A pin turned from input to output drives its last sampled level.
// R15: Requested history count is clamped to 32.
// R16: History reply is status, count, then entries newest first; 2+N bytes.
// R17: Status bits 7:4 read zero; bit 0 shows averaged (1) or raw (0).
// R18: Status bit 3 marks history cleared after over 64 spurious pulses.
// R19: A pulse is spurious if over 25% off either running average.
// R20: Status bit 2 shows the latest pulse went to the acquisition buffer.
// R21: Status bit 1 sets after 1792 ms without beats, clears after two beats.
// R22: Count byte is the push number of the newest entry, modulo 256.
// R23: Serial line: letter, optional decimal argument and spaces, then CR.
// R24: Sixteen-byte input FIFO, one command at a time, drop when full.
// R25: I2C reads past the prepared reply, or without a command, give 0x00.
// R26: Empty or cleared history entries read as zero.
// R27: Unknown command codes are dropped silently.
// R28: Direction and output masks apply to all pins in one cycle.
`timescale 1ns/1ps
`include "hrce_consts.svh"
module hrce_engine #(
  parameter int NODATA_CYC = `HRCE_NODATA_CYC, // Beat timeout in cycles.
  parameter int SETTLE_CYC = `HRCE_SETTLE_CYC, // Channel settle time in cycles.
  parameter logic [7:0] FW_TYPE = 8'h5a, // Arbitrary identification value.
  parameter logic [7:0] FW_REV = 8'h01 // Arbitrary identification value.
) (
  input wire logic CORE_CLK, // Core clock, 40 MHz.
  input wire logic RST_B, // Asynchronous reset, active low.
  input wire hrce_pkg::hrce_byte_s CMD_IN, // Received command byte with end mark.
  input wire logic CMD_VALID, // Command byte strobe.
  output logic CMD_FULL, // Input FIFO full, bytes dropped.
  input wire logic IF_I2C, // Pin: high selects the I2C link.
  output logic [7:0] TX_DATA, // Serial response character.
  output logic TX_VALID, // Serial character valid.
  input wire logic TX_READY, // Serial transmitter takes the character.
  input wire logic RD_REQ, // I2C front end asks for the next byte.
  output logic [7:0] RD_DATA, // I2C read byte, valid after a request.
  output logic [1:0] ADC_CHAN, // Analog channel select.
  output logic ADC_START, // Conversion start pulse.
  input wire logic ADC_DONE, // Conversion finished strobe.
  input wire logic [7:0] ADC_DATA, // Conversion result.
  input wire hrce_pkg::hrce_pulse_s PULSE, // Beat report from the rate engine.
  input wire hrce_pkg::hrce_hist_s HIST, // History push from the rate engine.
  output logic ALG_MODE, // Selected algorithm, 1 averaged.
  output logic SAVE_ALG, // Pulse: store algorithm as default.
  output logic SAVE_PORT, // Pulse: store port direction and value.
  input wire logic [4:0] GPIO_IN, // Port pins, input side.
  output logic [4:0] GPIO_OUT, // Port pins, output side.
  output logic [4:0] GPIO_OE // Port pins, drive enable.
);
  import hrce_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and declarations.
  logic [5:0] pin_m_q, pin_s_q;
  logic i2c;
  logic [4:0] gpio_s;
  hrce_byte_s fifo_q [`HRCE_FIFO_DEPTH];
  hrce_byte_s cur;
  logic [3:0] wr_q, rd_q;
  logic [4:0] cnt_q, cnt_d;
  logic push, pop;
  hrce_state_e st_q;
  logic [7:0] cmd_q, arg_q, rsp_cmd_q, adc_q, status, rsp_byte;
  logic have_arg_q, sp_q, known, needs_arg, exec_ok, is_digit, seq_end, rsp_load;
  logic [11:0] acc;
  logic [15:0] wait_q;
  logic [5:0] rsp_len_q, rsp_idx_q, hist_k, hist_n;
  logic dec_start, dec_busy;
  logic [4:0] oe_new, port_val;
  logic [7:0] hist_q [`HRCE_HIST_DEPTH];
  logic [4:0] wp_q;
  logic [5:0] filled_q;
  logic [7:0] count_q;
  logic [6:0] spur_q;
  logic [31:0] idle_q;
  logic bad_q, reacq_q, nodata_q, beat_seen_q, spurious, clear_hist, timeout;

  // Two flip-flops before any logic sees a pin.
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pin_m_q <= 6'h00;
      pin_s_q <= 6'h00;
    end else begin
      pin_m_q <= {IF_I2C, GPIO_IN};
      pin_s_q <= pin_m_q;
    end
  end
  assign i2c = pin_s_q[5];
  assign gpio_s = pin_s_q[4:0];

  ////////////////////////////////////////////////////////////////////////////////
  // Input FIFO; a byte arriving while full is lost.
  assign push = CMD_VALID && cnt_q != `HRCE_FIFO_DEPTH; // see R24
  assign pop = cnt_q != 5'h00 && (st_q == ST_IDLE || st_q == ST_ARG || st_q == ST_SKIP);
  assign cnt_d = cnt_q + 5'(push) - 5'(pop);
  assign cur = fifo_q[rd_q];

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      wr_q <= 4'h0;
      rd_q <= 4'h0;
      cnt_q <= 5'h00;
      CMD_FULL <= 1'b0;
    end else begin
      if (push) begin
        fifo_q[wr_q] <= CMD_IN;
        wr_q <= wr_q + 4'h1;
      end
      if (pop) begin
        rd_q <= rd_q + 4'h1;
      end
      cnt_q <= cnt_d;
      CMD_FULL <= cnt_d == `HRCE_FIFO_DEPTH;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command decode helpers.
  assign is_digit = cur.data >= `HRCE_DIGIT_0 && cur.data <= `HRCE_DIGIT_9;
  assign seq_end = i2c ? cur.last : cur.data == `HRCE_LINE_TERM; // see R23
  assign acc = {4'h0, arg_q} * 12'd10 + {4'h0, cur.data - `HRCE_DIGIT_0};

  always_comb begin
    known = 1'b1;
    needs_arg = 1'b0;
    case (cmd_q)
      `HRCE_OP_ADC, `HRCE_OP_DIR, `HRCE_OP_HIST, `HRCE_OP_PORT_WR,
      `HRCE_OP_MODE_WR: needs_arg = 1'b1;
      `HRCE_OP_PORT_RD, `HRCE_OP_MODE_RD, `HRCE_OP_VER: needs_arg = 1'b0;
      default: known = 1'b0; // see R27
    endcase
  end
  assign exec_ok = known && have_arg_q == needs_arg
    && !(cmd_q == `HRCE_OP_ADC && arg_q > `HRCE_ADC_CHAN_MAX); // see R09
  assign rsp_load = st_q == ST_EXEC || (st_q == ST_CONV && ADC_DONE);
  assign hist_n = (arg_q > `HRCE_HIST_MAX) ? 6'h20 : arg_q[5:0]; // see R15

  ////////////////////////////////////////////////////////////////////////////////
  // Command sequencer: parse, execute, convert and answer one command at a time.
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_q <= ST_IDLE;
      cmd_q <= 8'h00;
      arg_q <= 8'h00;
      have_arg_q <= 1'b0;
      sp_q <= 1'b0;
      wait_q <= 16'h0000;
      rsp_cmd_q <= 8'h00;
      rsp_len_q <= 6'h00;
      adc_q <= 8'h00;
      ADC_CHAN <= 2'h0;
      ADC_START <= 1'b0;
    end else begin
      ADC_START <= 1'b0;
      unique case (st_q)
        ST_IDLE: if (pop) begin
          cmd_q <= cur.data;
          arg_q <= 8'h00;
          have_arg_q <= 1'b0;
          sp_q <= 1'b0;
          if (i2c) st_q <= cur.last ? ST_EXEC : ST_ARG;
          else if (cur.data != `HRCE_LINE_TERM) st_q <= ST_ARG;
        end
        ST_ARG: if (pop) begin
          if (i2c) begin
            arg_q <= cur.data;
            have_arg_q <= 1'b1;
            st_q <= cur.last ? ST_EXEC : ST_SKIP;
          end else if (cur.data == `HRCE_LINE_TERM) begin
            st_q <= ST_EXEC;
          end else if (cur.data == `HRCE_SPACE) begin
            sp_q <= have_arg_q;
          end else if (is_digit && !sp_q && acc <= `HRCE_ARG_MAX) begin
            arg_q <= acc[7:0];
            have_arg_q <= 1'b1;
          end else begin
            st_q <= ST_SKIP; // see R23
          end
        end
        ST_SKIP: if (pop && seq_end) st_q <= ST_IDLE; // see R23
        ST_EXEC: begin
          rsp_len_q <= 6'h00;
          rsp_cmd_q <= cmd_q;
          st_q <= ST_IDLE;
          if (exec_ok) begin
            unique case (cmd_q)
              `HRCE_OP_ADC: begin
                ADC_CHAN <= arg_q[1:0]; // see R01
                wait_q <= 16'(SETTLE_CYC);
                st_q <= ST_SETTLE;
              end
              `HRCE_OP_HIST: rsp_len_q <= 6'h02 + hist_n; // see R03, R16
              `HRCE_OP_PORT_RD: rsp_len_q <= 6'h01; // see R04
              `HRCE_OP_MODE_RD, `HRCE_OP_VER: rsp_len_q <= 6'h02; // see R05, R08
              default: rsp_len_q <= 6'h00;
            endcase
            if (!i2c && cmd_q inside {`HRCE_OP_HIST, `HRCE_OP_PORT_RD,
                `HRCE_OP_MODE_RD, `HRCE_OP_VER}) st_q <= ST_RESP;
          end
        end
        ST_SETTLE: begin
          wait_q <= wait_q - 16'h0001;
          if (wait_q == 16'h0001) begin
            ADC_START <= 1'b1; // see R10
            st_q <= ST_CONV;
          end
        end
        ST_CONV: if (ADC_DONE) begin
          adc_q <= ADC_DATA;
          rsp_len_q <= 6'h01; // see R01
          st_q <= i2c ? ST_IDLE : ST_RESP; // see R09
        end
        ST_RESP: if (rsp_idx_q == rsp_len_q && !dec_busy) st_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Response byte selection by index.
  assign status = {4'h0, bad_q, reacq_q, nodata_q, ALG_MODE}; // see R17
  assign port_val = (GPIO_OE & GPIO_OUT) | (~GPIO_OE & gpio_s); // see R04
  assign hist_k = rsp_idx_q - 6'h02;

  always_comb begin
    rsp_byte = 8'h00;
    case (rsp_cmd_q)
      `HRCE_OP_ADC: rsp_byte = adc_q;
      `HRCE_OP_HIST: begin
        if (rsp_idx_q == 6'h00) rsp_byte = status;
        else if (rsp_idx_q == 6'h01) rsp_byte = count_q; // see R22
        else if (hist_k < filled_q) rsp_byte = hist_q[wp_q - 5'h01 - hist_k[4:0]]; // see R16
        else rsp_byte = 8'h00; // see R26
      end
      `HRCE_OP_PORT_RD: rsp_byte = {3'h0, port_val};
      `HRCE_OP_MODE_RD: rsp_byte = (rsp_idx_q == 6'h00) ? {7'h00, ALG_MODE}
                                                         : {3'h0, ~GPIO_OE}; // see R05
      `HRCE_OP_VER: rsp_byte = (rsp_idx_q == 6'h00) ? FW_TYPE : FW_REV; // see R08
      default: rsp_byte = 8'h00;
    endcase
  end

  // Response index: serial printing or I2C reads walk it; a new command rewinds it.
  assign dec_start = st_q == ST_RESP && !dec_busy && rsp_idx_q < rsp_len_q;
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rsp_idx_q <= 6'h00;
      RD_DATA <= 8'h00;
    end else if (rsp_load) begin
      rsp_idx_q <= 6'h00;
    end else if (dec_start) begin
      rsp_idx_q <= rsp_idx_q + 6'h01;
    end else if (RD_REQ) begin
      RD_DATA <= (rsp_idx_q < rsp_len_q) ? rsp_byte : 8'h00; // see R25
      if (rsp_idx_q != 6'h3f) rsp_idx_q <= rsp_idx_q + 6'h01;
    end
  end

  // ASCII printer for the serial link.
  hrce_dec_tx u_dec (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .start(dec_start),
    .value(rsp_byte),
    .last(rsp_idx_q == rsp_len_q - 6'h01),
    .ready(TX_READY),
    .busy(dec_busy),
    .chr(TX_DATA),
    .valid(TX_VALID)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Port pins and mode; masks apply to all five pins at once.
  assign oe_new = ~arg_q[4:0]; // see R11
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      GPIO_OE <= `HRCE_RST_OE; // see R13
      GPIO_OUT <= `HRCE_RST_OUT;
      ALG_MODE <= `HRCE_RST_ALG;
      SAVE_ALG <= 1'b0;
      SAVE_PORT <= 1'b0;
    end else begin
      SAVE_ALG <= 1'b0;
      SAVE_PORT <= 1'b0;
      if (st_q == ST_EXEC && exec_ok) begin
        if (cmd_q == `HRCE_OP_DIR) begin
          GPIO_OE <= oe_new; // see R02, R12, R28
          GPIO_OUT <= (GPIO_OUT & ~(oe_new & ~GPIO_OE))
                    | (gpio_s & oe_new & ~GPIO_OE); // see R14
        end
        if (cmd_q == `HRCE_OP_PORT_WR)
          GPIO_OUT <= (GPIO_OUT & ~GPIO_OE) | (arg_q[4:0] & GPIO_OE); // see R06, R28
        if (cmd_q == `HRCE_OP_MODE_WR) begin
          ALG_MODE <= arg_q[0]; // see R07
          SAVE_ALG <= arg_q[1];
          SAVE_PORT <= arg_q[2];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pulse discriminator: more than a quarter off the average is spurious.
  function automatic logic off_avg(input logic [7:0] r, input logic [7:0] a);
    logic [7:0] diff;
    diff = (r > a) ? r - a : a - r;
    off_avg = {diff, 2'b00} > {2'b00, a};
  endfunction : off_avg

  assign spurious = off_avg(PULSE.rate, PULSE.cur_avg) || off_avg(PULSE.rate, PULSE.acq_avg); // see R19
  assign clear_hist = PULSE.evt && spurious && spur_q == `HRCE_SPUR_LIMIT; // see R18
  assign timeout = !PULSE.evt && idle_q == 32'(NODATA_CYC - 1);

  // Status flags; a set in the same cycle as a clear wins.
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      spur_q <= 7'h00;
      bad_q <= 1'b0;
      reacq_q <= 1'b0;
      nodata_q <= 1'b1;
      beat_seen_q <= 1'b0;
      idle_q <= 32'h0;
    end else begin
      if (PULSE.evt) begin
        spur_q <= !spurious ? 7'h00 : ((spur_q > `HRCE_SPUR_LIMIT) ? spur_q : spur_q + 7'h01);
        reacq_q <= off_avg(PULSE.rate, PULSE.cur_avg); // see R20
      end
      if (clear_hist) bad_q <= 1'b1; // see R18
      else if (HIST.push) bad_q <= 1'b0;
      idle_q <= PULSE.evt ? 32'h0 : (timeout ? idle_q : idle_q + 32'h1);
      if (timeout) begin
        nodata_q <= 1'b1; // see R21
        beat_seen_q <= 1'b0;
      end else if (PULSE.evt && nodata_q) begin
        nodata_q <= !beat_seen_q; // see R21
        beat_seen_q <= !beat_seen_q;
      end
    end
  end

  // History ring, newest at the write pointer minus one.
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      wp_q <= 5'h00;
      filled_q <= 6'h00;
      count_q <= 8'h00;
    end else if (clear_hist) begin
      filled_q <= 6'h00; // see R26
    end else if (HIST.push) begin
      hist_q[wp_q] <= HIST.rate;
      wp_q <= wp_q + 5'h01;
      filled_q <= (filled_q == `HRCE_HIST_DEPTH) ? filled_q : filled_q + 6'h01;
      count_q <= count_q + 8'h01; // see R22
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);

  fifo_drop_a: assert property (cnt_q == `HRCE_FIFO_DEPTH && !pop |=> cnt_q == `HRCE_FIFO_DEPTH) // see R24
    else $error("FIFO took a byte while full");
  adc_range_a: assert property (st_q == ST_EXEC && cmd_q == `HRCE_OP_ADC // see R09
    && arg_q > `HRCE_ADC_CHAN_MAX |=> st_q == ST_IDLE && !ADC_START
    && ADC_CHAN == $past(ADC_CHAN))
    else $error("Bad channel not ignored");
  adc_settle_a: assert property (st_q == ST_EXEC && exec_ok && cmd_q == `HRCE_OP_ADC // see R10
    |-> ##201 ADC_START)
    else $error("Conversion start not after settle time");
  dir_mask_a: assert property (st_q == ST_EXEC && exec_ok && cmd_q == `HRCE_OP_DIR // see R11
    |=> GPIO_OE == ~$past(arg_q[4:0]))
    else $error("Direction mask not applied");
  keep_level_a: assert property (st_q == ST_EXEC && exec_ok && cmd_q == `HRCE_OP_DIR // see R14
    |=> ((GPIO_OE & ~$past(GPIO_OE)) & (GPIO_OUT ^ $past(gpio_s))) == 5'h00)
    else $error("New output lost its sampled level");
  hist_len_a: assert property (st_q == ST_EXEC && exec_ok && cmd_q == `HRCE_OP_HIST // see R15
    |=> rsp_len_q <= 6'h22 && rsp_len_q >= 6'h02)
    else $error("History length out of range");
  bad_data_a: assert property (clear_hist |=> bad_q && filled_q == 6'h00) // see R18
    else $error("History not cleared after spurious run");
  reacq_a: assert property (PULSE.evt |=> reacq_q == $past(off_avg(PULSE.rate, PULSE.cur_avg))) // see R20
    else $error("Reacquire flag wrong");
  nodata_a: assert property (timeout |=> nodata_q ##1 (nodata_q || $past(PULSE.evt))) // see R21
    else $error("No-data flag not held");
  empty_read_a: assert property (RD_REQ && !rsp_load && !dec_start // see R25
    && rsp_idx_q >= rsp_len_q |=> RD_DATA == 8'h00)
    else $error("Read past reply not zero");
  unknown_a: assert property (st_q == ST_EXEC && !known |=> st_q == ST_IDLE && rsp_len_q == 6'h00) // see R27
    else $error("Unknown command answered");

  adc_run_c: cover property (ADC_START ##[1:20] ADC_DONE);
  hist_serial_c: cover property (st_q == ST_RESP && rsp_cmd_q == `HRCE_OP_HIST ##1 TX_VALID);
  bad_data_c: cover property (clear_hist);
  i2c_read_c: cover property (RD_REQ && rsp_idx_q < rsp_len_q);
endmodule : hrce_engine

/* hrce_consts.svh */
// Purpose: Shared constants of the heart-rate command engine.
// Assumes: A 40 MHz core clock.
// Notes: Included by the engine and the decimal transmitter.
`ifndef HRCE_CONSTS_SVH
`define HRCE_CONSTS_SVH
`define HRCE_OP_ADC 8'h41
`define HRCE_OP_DIR 8'h44
`define HRCE_OP_HIST 8'h47
`define HRCE_OP_PORT_RD 8'h49
`define HRCE_OP_MODE_RD 8'h4d
`define HRCE_OP_PORT_WR 8'h4f
`define HRCE_OP_MODE_WR 8'h53
`define HRCE_OP_VER 8'h56
`define HRCE_LINE_TERM 8'h0d
`define HRCE_SPACE 8'h20
`define HRCE_DIGIT_0 8'h30
`define HRCE_DIGIT_9 8'h39
`define HRCE_ADC_CHAN_MAX 8'h03
`define HRCE_ARG_MAX 12'h0ff
`define HRCE_HIST_DEPTH 6'h20
`define HRCE_HIST_MAX 8'h20
`define HRCE_SPUR_LIMIT 7'h40
`define HRCE_FIFO_DEPTH 5'h10
`define HRCE_CLK_PERIOD_NS 25
`define HRCE_SETTLE_NS 5000
`define HRCE_SETTLE_CYC ((`HRCE_SETTLE_NS + `HRCE_CLK_PERIOD_NS - 1) / `HRCE_CLK_PERIOD_NS)
`define HRCE_NODATA_MS 1792
`define HRCE_NODATA_CYC (`HRCE_NODATA_MS * 1000000 / `HRCE_CLK_PERIOD_NS)
`define HRCE_ST_BAD 3
`define HRCE_ST_REACQ 2
`define HRCE_ST_NODATA 1
`define HRCE_ST_ALG 0
`define HRCE_RST_ALG 1'b1
`define HRCE_RST_OE 5'h1f
`define HRCE_RST_OUT 5'h00
`endif

/* hrce_pkg.sv */
// Purpose: Types of the heart-rate command engine.
// Assumes: Nothing beyond the constants header.
// Notes: Carriers for command bytes, beat reports and history pushes.
package hrce_pkg;
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } hrce_byte_s;
  typedef struct packed {
    logic evt;
    logic [7:0] rate;
    logic [7:0] cur_avg;
    logic [7:0] acq_avg;
  } hrce_pulse_s;
  typedef struct packed {
    logic push;
    logic [7:0] rate;
  } hrce_hist_s;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ARG, ST_SKIP, ST_EXEC, ST_SETTLE, ST_CONV, ST_RESP
  } hrce_state_e;
endpackage : hrce_pkg

/* hrce_dec_tx.sv */
// Purpose: Turns one response byte into decimal ASCII characters.
// Assumes: The sink takes characters with a valid and ready handshake.
// Notes: Each value ends in a space; the last one also sends the line terminator.
`timescale 1ns/1ps
`include "hrce_consts.svh"
module hrce_dec_tx (
  input wire logic clk, // Core clock.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic start, // Load a new value.
  input wire logic [7:0] value, // Value to print.
  input wire logic last, // Terminate the line after this value.
  input wire logic ready, // Sink accepts the character.
  output logic busy, // Characters still pending.
  output logic [7:0] chr, // Character out.
  output logic valid // Character valid.
);
  import hrce_pkg::*;

  logic [3:0] hun_q, ten_q, one_q, hun_d, ten_d, one_d;
  logic [2:0] pos_q, first_d;
  logic last_q, valid_q;
  logic [7:0] chr_q;

  // Character at a position: hundreds, tens, ones, space, terminator.
  function automatic logic [7:0] pick(input logic [2:0] p, input logic [3:0] h,
                                      input logic [3:0] t, input logic [3:0] o);
    case (p)
      3'h0: pick = `HRCE_DIGIT_0 + {4'h0, h};
      3'h1: pick = `HRCE_DIGIT_0 + {4'h0, t};
      3'h2: pick = `HRCE_DIGIT_0 + {4'h0, o};
      3'h3: pick = `HRCE_SPACE;
      default: pick = `HRCE_LINE_TERM;
    endcase
  endfunction : pick

  // Split the value into digits and skip leading zeros.
  always_comb begin
    hun_d = 4'(value / 8'd100);
    ten_d = 4'((value / 8'd10) % 8'd10);
    one_d = 4'(value % 8'd10);
    first_d = (hun_d != 4'h0) ? 3'h0 : ((ten_d != 4'h0) ? 3'h1 : 3'h2);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Character sequencer; a held character stays put until the sink takes it.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hun_q <= 4'h0;
      ten_q <= 4'h0;
      one_q <= 4'h0;
      pos_q <= 3'h0;
      last_q <= 1'b0;
      valid_q <= 1'b0;
      chr_q <= 8'h00;
    end else if (start) begin
      hun_q <= hun_d;
      ten_q <= ten_d;
      one_q <= one_d;
      pos_q <= first_d;
      last_q <= last;
      valid_q <= 1'b1;
      chr_q <= pick(first_d, hun_d, ten_d, one_d);
    end else if (valid_q && ready) begin
      if ((pos_q == 3'h3 && !last_q) || pos_q == 3'h4) begin
        valid_q <= 1'b0;
      end else begin
        pos_q <= pos_q + 3'h1;
        chr_q <= pick(pos_q + 3'h1, hun_q, ten_q, one_q);
      end
    end
  end

  assign busy = valid_q;
  assign valid = valid_q;
  assign chr = chr_q;
endmodule : hrce_dec_tx

/* hrce_adc_model.sv */
// Purpose: Converter model that answers start pulses from the engine.
// Assumes: Start is a one-cycle pulse on the core clock.
// Notes: The result carries the channel, so a wrong select shows.
`timescale 1ns/1ps
module hrce_adc_model (
  input wire logic clk, // Core clock.
  input wire logic [1:0] chan, // Channel select.
  input wire logic start, // Start pulse.
  input wire logic [3:0] lag, // Answer delay.
  output logic done = 1'b0, // Done pulse.
  output logic [7:0] data = 8'h00 // Result.
);
  int n = -1;
  // Data toggles outside the done cycle so a stale sample never matches.
  always @(posedge clk) begin
    done <= 1'b0;
    data <= ~data;
    if (start) n <= lag;
    else if (n == 0) begin
      done <= 1'b1;
      data <= {6'h28, chan};
      n <= -1;
    end else if (n > 0) n <= n - 1;
  end
endmodule : hrce_adc_model

/* test_heart_rate_command_engine.sv */
// Purpose: Self-checking bench of the command engine over the I2C and serial sides.
// Assumes: Reads and characters are checked by watchers against a queue of notes.
// Notes: Beat reports drive a spurious run; history is fed by direct pushes.
`timescale 1ns/1ps
module test_heart_rate_command_engine;
  import hrce_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, cmd_valid = 1'b0, rd_req = 1'b0;
  logic adc_start, adc_done, alg_mode, r1 = 1'b0, r2 = 1'b0;
  logic [7:0] rd_data, adc_data, v, g;
  logic [1:0] adc_chan;
  logic [4:0] gpio_in = 5'h00, gpio_out, gpio_oe;
  hrce_byte_s cmd_in = '0;
  hrce_hist_s hist = '0;
  logic if_i2c = 1'b1, tx_ready = 1'b0, tx_valid, cmd_full, save_alg, save_port;
  logic [7:0] tx_data;
  logic [1:0] saved = 2'h0;
  hrce_pulse_s pulse = '0;
  // Expected serial text: "162 " and terminator, then "90 1 " and terminator.
  logic [7:0] s[11] = '{8'h31, 8'h36, 8'h32, 8'h20, 8'h0d, 8'h39, 8'h30, 8'h20, 8'h31, 8'h20,
    8'h0d};
  logic [7:0] q[$];
  int fail_count = 0, n_checks = 0, seed = 32'h0005;
  always #12.5 clk = ~clk;
  hrce_engine #(.NODATA_CYC(200)) DUT (.CORE_CLK(clk), .RST_B(rst_b), .CMD_IN(cmd_in),
    .CMD_VALID(cmd_valid), .CMD_FULL(cmd_full), .IF_I2C(if_i2c), .TX_DATA(tx_data),
    .TX_VALID(tx_valid), .TX_READY(tx_ready), .RD_REQ(rd_req), .RD_DATA(rd_data),
    .ADC_CHAN(adc_chan), .ADC_START(adc_start), .ADC_DONE(adc_done), .ADC_DATA(adc_data),
    .PULSE(pulse), .HIST(hist), .ALG_MODE(alg_mode), .SAVE_ALG(save_alg),
    .SAVE_PORT(save_port), .GPIO_IN(gpio_in), .GPIO_OUT(gpio_out), .GPIO_OE(gpio_oe));
  hrce_adc_model adc (.clk(clk), .chan(adc_chan), .start(adc_start), .lag(4'h5),
    .done(adc_done), .data(adc_data));
  task chk(input logic [7:0] a, input logic [7:0] e);
    n_checks++;
    if (a !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, a, e);
    end
  endtask : chk
  task test_done;
    if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  // Sends a code and an optional argument, the stop mark on the final byte.
  task send(input logic [7:0] c, input logic [7:0] a, input bit has);
    @(negedge clk) cmd_in = '{data: c, last: !has};
    cmd_valid = 1'b1;
    if (has) @(negedge clk) cmd_in = '{data: a, last: 1'b1};
    @(negedge clk) cmd_valid = 1'b0;
    repeat (8) @(negedge clk);
  endtask : send
  // Requests one read byte and notes what it must be.
  task rd(input logic [7:0] e);
    @(negedge clk) rd_req = 1'b1;
    q.push_back(e);
    @(negedge clk) rd_req = 1'b0;
    repeat (2) @(negedge clk);
  endtask : rd
  // Watcher compares each settled read byte with the oldest note.
  always @(posedge clk) begin
    r1 <= rd_req;
    r2 <= r1;
  end
  always @(negedge clk) if (r2) chk(rd_data, q.pop_front());
  // Serial sink takes characters at random; each character taken is checked.
  always @(negedge clk) begin
    tx_ready = 1'($random(seed));
    if (tx_valid && tx_ready) chk(tx_data, q.pop_front());
  end
  // Collects the save pulses of mode writes.
  always @(posedge clk) if (rst_b) saved <= saved | {save_port, save_alg};
  initial begin
    #200000;
    fail_count++;
    test_done;
  end
  initial begin
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    chk(gpio_oe, 8'h1f);
    chk(gpio_out, 8'h00);
    send(8'h41, 8'h05, 1);
    rd(8'h00);
    send(8'h41, 8'h02, 1);
    repeat (300) @(negedge clk);
    chk(adc_chan, 8'h02);
    rd(8'ha2);
    send(8'h56, 8'h00, 0);
    rd(8'h5a);
    rd(8'h01);
    rd(8'h00);
    send(8'h44, 8'he3, 1);
    chk(gpio_oe, 8'h1c);
    send(8'h4d, 8'h00, 0);
    rd(8'h01);
    rd(8'h03);
    v = $random(seed);
    g = $random(seed);
    gpio_in = g[4:0];
    send(8'h4f, v, 1);
    chk(gpio_out & 5'h1c, v & 8'h1c);
    send(8'h49, 8'h00, 0);
    rd((g & 8'h03) | (v & 8'h1c));
    for (int i = 0; i < 3; i++) begin
      @(negedge clk) hist = '{push: 1'b1, rate: 8'h3c + i};
      @(negedge clk) hist = '0;
    end
    send(8'h47, 8'h28, 1);
    rd(8'h03);
    rd(8'h03);
    for (int i = 0; i < 32; i++) rd(i < 3 ? 8'h3e - i : 8'h00);
    rd(8'h00);
    // A run of 65 spurious beats clears the history and raises bad data.
    for (int i = 0; i < 65; i++) begin
      @(negedge clk) pulse = '{1'b1, 8'h80, 8'h40, 8'h40};
      @(negedge clk) pulse = '0;
    end
    send(8'h47, 8'h01, 1);
    rd(8'h0d);
    rd(8'h03);
    rd(8'h00);
    send(8'h53, 8'hf8, 1);
    chk(alg_mode, 8'h00);
    chk(saved, 8'h00);
    send(8'h4d, 8'h00, 0);
    rd(8'h00);
    rd(8'h03);
    send(8'h53, 8'h06, 1);
    chk(saved, 8'h03);
    send(8'h44, 8'h00, 1);
    chk(gpio_out, (g & 8'h03) | (v & 8'h1c));
    // Serial side: analog read and version, with the FIFO filled meanwhile.
    if_i2c = 1'b0;
    repeat (2) @(negedge clk);
    foreach (s[i]) q.push_back(s[i]);
    send(8'h41, 8'h32, 1);
    repeat (18) begin
      @(negedge clk) cmd_in = '{data: 8'h0d, last: 1'b1};
      cmd_valid = 1'b1;
    end
    @(negedge clk) cmd_valid = 1'b0;
    chk(cmd_full, 8'h01);
    repeat (300) @(negedge clk);
    chk(cmd_full, 8'h00);
    send(8'h56, 8'h0d, 1);
    repeat (60) @(negedge clk);
    chk(8'(q.size()), 8'h00);
    test_done;
  end
endmodule : test_heart_rate_command_engine
